// File: irz_pkg.sv
// Constants and types for the image resizer block
// Function
// - Ratio parameters 64..1024, factor 256/parameter
// - Horizontal pass first, then vertical pass
// - Source select: live stream or memory
// - Live frames framed by syncs, offsets from corner
// - Capture controller wins when both enabled
// - Fetch address steps by input line step
// - Single-component 8-bit mode, one component per run
// - Byte order selects luma-first or chroma-first
// - Results go to memory with output geometry
// - Addresses and steps ignore five low bits
// - Same polyphase algorithm both directions
// - 8 phases/4 taps or 4 phases/7 taps
// - 32 signed S10Q8 coefficients per direction
package irz_pkg;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_RATIO = 12'h004;
   localparam logic [11:0] OFF_START = 12'h008;
   localparam logic [11:0] OFF_IN_SIZE = 12'h00C;
   localparam logic [11:0] OFF_OUT_SIZE = 12'h010;
   localparam logic [11:0] OFF_IN_ADDR = 12'h014;
   localparam logic [11:0] OFF_IN_STEP = 12'h018;
   localparam logic [11:0] OFF_OUT_ADDR = 12'h01C;
   localparam logic [11:0] OFF_OUT_STEP = 12'h020;
   localparam logic [11:0] OFF_SCR_ADDR = 12'h024;
   localparam logic [11:0] OFF_STATUS = 12'h028;
   localparam logic [11:0] OFF_HCOEF = 12'h080;
   localparam logic [11:0] OFF_COEF_END = 12'h180;
   localparam int CTRL_START = 0;
   localparam int CTRL_SRC = 1;
   localparam int CTRL_TYP = 2;
   localparam int CTRL_ORD = 3;
   localparam int CTRL_EDGE = 4;
   localparam int ST_BUSY = 0;
   localparam int ST_OVR = 1;
   localparam int ST_VPASS = 2;
   localparam int HI_LSB = 16;
   localparam logic [10:0] RSZ_MIN = 11'h040;
   localparam logic [10:0] RSZ_MAX = 11'h400;
   localparam logic [10:0] RSZ_P8_MAX = 11'h200;
   localparam logic [10:0] RST_RSZ = 11'h100;
   localparam logic [12:0] RST_SIZE = 13'h0000;
   localparam logic [12:0] LV_ROW_RST = 13'h1FFF;
   localparam logic [23:0] RND_P8 = 24'h000010;
   localparam logic [23:0] RND_P4 = 24'h000020;
   localparam logic [2:0] TAPS_P8 = 3'h4;
   localparam logic [2:0] TAPS_P4 = 3'h7;
   localparam int NTAP = 7;
   localparam int NCOEF = 64;
   typedef enum logic [2:0] {st_idle, st_hfetch, st_hwr, st_vfetch, st_vwr} irz_state_t;
endpackage : irz_pkg

// File: irz_resizer.sv
// Image resizer: APB registers, live/memory input, two-pass polyphase scaler
`timescale 1ns/1ps
`default_nettype none
module irz_resizer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cap_en,
   input wire logic cap_hsync,
   input wire logic cap_vsync,
   input wire logic cap_valid,
   input wire logic [15:0] cap_data,
   input wire logic prv_en,
   input wire logic prv_hsync,
   input wire logic prv_vsync,
   input wire logic prv_valid,
   input wire logic [15:0] prv_data,
   output logic mem_rd_req,
   output logic [31:0] mem_rd_addr,
   input wire logic mem_rd_ack,
   input wire logic [7:0] mem_rd_data,
   output logic mem_wr_req,
   output logic [31:0] mem_wr_addr,
   output logic [7:0] mem_wr_data,
   input wire logic mem_wr_ack,
   output logic busy
);
   irz_pkg::irz_state_t state_q;
   logic [4:1] ctrl_q;
   logic [10:0] hrsz_q, vrsz_q;
   logic [12:0] scol_q, srow_q, iw_q, ih_q, ow_q, oh_q;
   logic [31:5] ina_q, ins_q, outa_q, outs_q, scr_q;
   logic [9:0] coef_q [irz_pkg::NCOEF];
   logic [7:0] win_q [irz_pkg::NTAP];
   logic [12:0] n_q, j_q, r_q, x_q, y_q, lv_col_q, lv_row_q;
   logic [23:0] pos_q;
   logic [2:0] t_q;
   logic [7:0] prev_q;
   logic ovr_q, rd_req_q, wr_req_q;
   logic [31:0] rd_addr_q, wr_addr_q, prdata_q;
   logic [7:0] wr_data_q;

   function automatic logic [10:0] clamp_rsz(input logic [10:0] v);
      if (v < irz_pkg::RSZ_MIN) return irz_pkg::RSZ_MIN;
      if (v > irz_pkg::RSZ_MAX) return irz_pkg::RSZ_MAX;
      return v;
   endfunction : clamp_rsz

   function automatic logic [7:0] sat8(input logic signed [13:0] v);
      if (v < 0) return 8'h00;
      if (v > 14'sd255) return 8'hFF;
      return v[7:0];
   endfunction : sat8

   // APB decode
   wire acc = psel & penable;
   wire aligned = paddr[1:0] == 2'b00;
   wire hit_reg = aligned & (paddr <= irz_pkg::OFF_STATUS);
   wire hit_coef = aligned & (paddr >= irz_pkg::OFF_HCOEF) & (paddr < irz_pkg::OFF_COEF_END);
   wire [5:0] coef_idx = {paddr[8], paddr[6:2]};
   wire frozen = busy & (paddr != irz_pkg::OFF_STATUS);
   wire wr_ok = acc & pwrite & (hit_reg | hit_coef) & ~frozen;
   wire src_mem = ctrl_q[irz_pkg::CTRL_SRC];
   wire typ8 = ctrl_q[irz_pkg::CTRL_TYP];
   wire ord_cy = ctrl_q[irz_pkg::CTRL_ORD];
   wire go = wr_ok & (paddr == irz_pkg::OFF_CTRL) & pwdata[irz_pkg::CTRL_START];
   assign pready = 1'b1;
   assign pslverr = acc & (~(hit_reg | hit_coef) | (pwrite & frozen));
   assign prdata = prdata_q;
   assign busy = state_q != irz_pkg::st_idle;

   // Live stream: capture controller owns the port when both drive it
   wire s_hs = cap_en ? cap_hsync : prv_en & prv_hsync;
   wire s_vs = cap_en ? cap_vsync : prv_en & prv_vsync;
   wire s_vld = cap_en ? cap_valid : prv_en & prv_valid;
   wire [15:0] s_dat = cap_en ? cap_data : prv_data;
   wire [7:0] s_luma = ord_cy ? s_dat[15:8] : s_dat[7:0];

   // Direction-shared polyphase geometry
   wire vp = (state_q == irz_pkg::st_vfetch) | (state_q == irz_pkg::st_vwr);
   wire [10:0] rsz = vp ? clamp_rsz(vrsz_q) : clamp_rsz(hrsz_q);
   wire p8 = rsz <= irz_pkg::RSZ_P8_MAX;
   wire [2:0] taps = p8 ? irz_pkg::TAPS_P8 : irz_pkg::TAPS_P4;
   wire [23:0] pos_r = pos_q + (p8 ? irz_pkg::RND_P8 : irz_pkg::RND_P4);
   wire [15:0] ip = pos_r[23:8];
   wire [2:0] phase = p8 ? pos_r[7:5] : {1'b0, pos_r[7:6]};
   wire h_ready = {3'b000, n_q} == ip + {13'h0000, taps};

   logic signed [21:0] prod [irz_pkg::NTAP];
   for (genvar k = 0; k < irz_pkg::NTAP; k++) begin : g_tap
      // Coefficient layout: phase-major, 4 or 8 slots per phase
      wire [4:0] ci = p8 ? {phase[2:0], 2'(k)} : {phase[1:0], 3'(k)};
      wire signed [9:0] c = coef_q[{vp, ci}];
      wire [2:0] wi = 3'(taps - 3'(k) - 3'h1);
      wire [7:0] smp = win_q[wi];
      assign prod[k] = (3'(k) < taps) ? 22'(c * $signed({1'b0, smp})) : 22'sh0;
   end

   logic signed [21:0] acc_sum;
   always_comb begin
      acc_sum = 22'sh0;
      for (int k = 0; k < irz_pkg::NTAP; k++) begin
         acc_sum = acc_sum + prod[k];
      end
   end
   // S10Q8 product sum: round then drop the 8 fraction bits
   wire signed [21:0] rnd = (acc_sum + 22'sh80) >>> 8;
   wire [7:0] filt = sat8(rnd[21] ? -14'sd1 : (|rnd[20:13] ? 14'sd256 : 14'(rnd[12:0])));
   wire signed [13:0] edge_v = 14'($signed({6'h00, filt})) + ((14'($signed({6'h00, filt})) - 14'($signed({6'h00, prev_q}))) >>> 1);
   wire use_edge = ctrl_q[irz_pkg::CTRL_EDGE] & (j_q != 13'h0000);
   wire [7:0] h_pix = use_edge ? sat8(edge_v) : filt;

   // Live window acceptance
   wire [12:0] col_want = scol_q + n_q;
   wire lv_match = ~src_mem & s_vld & (lv_row_q == srow_q + r_q) & (lv_col_q == col_want) & (n_q < iw_q);
   wire lv_take = lv_match & (state_q == irz_pkg::st_hfetch) & ~h_ready;
   // No buffer on the live side: a pixel arriving mid-write is lost
   wire ovr_set = lv_match & (state_q == irz_pkg::st_hwr);

   // Memory addresses; base and step keep only bits 31:5
   wire [31:0] row_off_in = 32'(r_q * {ins_q, 5'h00});
   wire [12:0] col_byte = typ8 ? col_want : 13'({col_want, 1'b0} + {12'h000, ord_cy});
   wire [31:0] h_rd = {ina_q, 5'h00} + row_off_in + {19'h00000, col_byte};
   wire [31:0] h_wr = {scr_q, 5'h00} + 32'(r_q * {outs_q, 5'h00}) + {19'h00000, j_q};
   wire [31:0] v_rd = {scr_q, 5'h00} + 32'((ip + {13'h0000, t_q}) * {outs_q, 5'h00}) + {19'h00000, x_q};
   wire [31:0] v_wr = {outa_q, 5'h00} + 32'(y_q * {outs_q, 5'h00}) + {19'h00000, x_q};
   wire h_need = src_mem & (state_q == irz_pkg::st_hfetch) & ~h_ready & (n_q < iw_q);
   wire rd_d = (h_need | (state_q == irz_pkg::st_vfetch)) & ~(rd_req_q & mem_rd_ack);
   wire wr_d = ((state_q == irz_pkg::st_hwr) | (state_q == irz_pkg::st_vwr)) & ~(wr_req_q & mem_wr_ack);
   wire rd_done = rd_req_q & mem_rd_ack;
   wire wr_done = wr_req_q & mem_wr_ack;
   wire shift = rd_done | lv_take;
   wire [7:0] new_smp = src_mem | vp ? mem_rd_data : s_luma;
   assign mem_rd_req = rd_req_q;
   assign mem_rd_addr = rd_addr_q;
   assign mem_wr_req = wr_req_q;
   assign mem_wr_addr = wr_addr_q;
   assign mem_wr_data = wr_data_q;

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      case (paddr)
         irz_pkg::OFF_CTRL: rd_mux = {27'h0000000, ctrl_q, 1'b0};
         irz_pkg::OFF_RATIO: rd_mux = {5'h00, vrsz_q, 5'h00, hrsz_q};
         irz_pkg::OFF_START: rd_mux = {3'h0, srow_q, 3'h0, scol_q};
         irz_pkg::OFF_IN_SIZE: rd_mux = {3'h0, ih_q, 3'h0, iw_q};
         irz_pkg::OFF_OUT_SIZE: rd_mux = {3'h0, oh_q, 3'h0, ow_q};
         irz_pkg::OFF_IN_ADDR: rd_mux = {ina_q, 5'h00};
         irz_pkg::OFF_IN_STEP: rd_mux = {ins_q, 5'h00};
         irz_pkg::OFF_OUT_ADDR: rd_mux = {outa_q, 5'h00};
         irz_pkg::OFF_OUT_STEP: rd_mux = {outs_q, 5'h00};
         irz_pkg::OFF_SCR_ADDR: rd_mux = {scr_q, 5'h00};
         irz_pkg::OFF_STATUS: rd_mux = {29'h00000000, vp, ovr_q, busy};
         default: rd_mux = hit_coef ? {{22{coef_q[coef_idx][9]}}, coef_q[coef_idx]} : 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= '0;
         hrsz_q <= irz_pkg::RST_RSZ;
         vrsz_q <= irz_pkg::RST_RSZ;
         {scol_q, srow_q, iw_q, ih_q, ow_q, oh_q} <= {6{irz_pkg::RST_SIZE}};
         {ina_q, ins_q, outa_q, outs_q, scr_q} <= '0;
         prdata_q <= '0;
      end else begin
         if (psel & ~penable) prdata_q <= rd_mux;
         if (wr_ok) begin
            case (paddr)
               irz_pkg::OFF_CTRL: ctrl_q <= pwdata[4:1];
               irz_pkg::OFF_RATIO: {vrsz_q, hrsz_q} <= {pwdata[26:16], pwdata[10:0]};
               irz_pkg::OFF_START: {srow_q, scol_q} <= {pwdata[28:16], pwdata[12:0]};
               irz_pkg::OFF_IN_SIZE: {ih_q, iw_q} <= {pwdata[28:16], pwdata[12:0]};
               irz_pkg::OFF_OUT_SIZE: {oh_q, ow_q} <= {pwdata[28:16], pwdata[12:0]};
               irz_pkg::OFF_IN_ADDR: ina_q <= pwdata[31:5];
               irz_pkg::OFF_IN_STEP: ins_q <= pwdata[31:5];
               irz_pkg::OFF_OUT_ADDR: outa_q <= pwdata[31:5];
               irz_pkg::OFF_OUT_STEP: outs_q <= pwdata[31:5];
               irz_pkg::OFF_SCR_ADDR: scr_q <= pwdata[31:5];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (wr_ok & hit_coef) coef_q[coef_idx] <= pwdata[9:0];
   end

   // Live frame position from syncs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lv_row_q <= irz_pkg::LV_ROW_RST;
         lv_col_q <= '0;
      end else if (s_vs) begin
         lv_row_q <= irz_pkg::LV_ROW_RST;
         lv_col_q <= '0;
      end else if (s_hs) begin
         lv_row_q <= lv_row_q + 13'h0001;
         lv_col_q <= '0;
      end else if (s_vld) begin
         lv_col_q <= lv_col_q + 13'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_q <= 1'b0;
         rd_req_q <= 1'b0;
         wr_req_q <= 1'b0;
         rd_addr_q <= '0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
      end else begin
         // A new overrun outranks a same-cycle clear
         if (ovr_set) ovr_q <= 1'b1;
         else if (acc & pwrite & (paddr == irz_pkg::OFF_STATUS) & pwdata[irz_pkg::ST_OVR]) ovr_q <= 1'b0;
         rd_req_q <= rd_d;
         wr_req_q <= wr_d;
         rd_addr_q <= vp ? v_rd : h_rd;
         wr_addr_q <= vp ? v_wr : h_wr;
         wr_data_q <= vp ? filt : h_pix;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < irz_pkg::NTAP; i++) win_q[i] <= '0;
      end else if (shift) begin
         win_q[0] <= new_smp;
         for (int i = 1; i < irz_pkg::NTAP; i++) win_q[i] <= win_q[i-1];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= irz_pkg::st_idle;
         {n_q, j_q, r_q, x_q, y_q} <= '0;
         pos_q <= '0;
         t_q <= '0;
         prev_q <= '0;
      end else begin
         case (state_q)
            irz_pkg::st_idle: if (go) begin
               {n_q, j_q, r_q, pos_q} <= '0;
               state_q <= irz_pkg::st_hfetch;
            end
            irz_pkg::st_hfetch: begin
               if (shift) n_q <= n_q + 13'h0001;
               if (h_ready) state_q <= irz_pkg::st_hwr;
            end
            irz_pkg::st_hwr: if (wr_done) begin
               prev_q <= filt;
               if (j_q == ow_q - 13'h0001) begin
                  {n_q, j_q, pos_q} <= '0;
                  r_q <= r_q + 13'h0001;
                  if (r_q == ih_q - 13'h0001) begin
                     {x_q, y_q, t_q} <= '0;
                     state_q <= irz_pkg::st_vfetch;
                  end else begin
                     state_q <= irz_pkg::st_hfetch;
                  end
               end else begin
                  j_q <= j_q + 13'h0001;
                  pos_q <= pos_q + {13'h0000, rsz};
                  state_q <= irz_pkg::st_hfetch;
               end
            end
            irz_pkg::st_vfetch: if (rd_done) begin
               t_q <= t_q + 3'h1;
               if (t_q + 3'h1 == taps) state_q <= irz_pkg::st_vwr;
            end
            irz_pkg::st_vwr: if (wr_done) begin
               t_q <= '0;
               state_q <= irz_pkg::st_vfetch;
               if (y_q == oh_q - 13'h0001) begin
                  y_q <= '0;
                  pos_q <= '0;
                  x_q <= x_q + 13'h0001;
                  if (x_q == ow_q - 13'h0001) state_q <= irz_pkg::st_idle;
               end else begin
                  y_q <= y_q + 13'h0001;
                  pos_q <= pos_q + {13'h0000, rsz};
               end
            end
            default: state_q <= irz_pkg::st_idle;
         endcase
      end
   end
endmodule : irz_resizer
`default_nettype wire

// File: irz_resizer_properties.sv
// Port-level checker for the image resizer
`timescale 1ns/1ps
`default_nettype none
module irz_resizer_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic mem_rd_req,
   input wire logic [31:0] mem_rd_addr,
   input wire logic mem_rd_ack,
   input wire logic mem_wr_req,
   input wire logic [31:0] mem_wr_addr,
   input wire logic [7:0] mem_wr_data,
   input wire logic mem_wr_ack,
   input wire logic busy
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_acc = psel && penable && pwrite;
   property p_rd_hold; mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read request moved before ack");
   property p_rd_drop; mem_rd_ack |=> !mem_rd_req; endproperty
   a_rd_drop: assert property (p_rd_drop) else $error("read request kept after ack");
   property p_wr_hold; mem_wr_req && !mem_wr_ack |=> mem_wr_req && $stable({mem_wr_addr, mem_wr_data}); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write request moved before ack");
   property p_wr_drop; mem_wr_ack |=> !mem_wr_req; endproperty
   a_wr_drop: assert property (p_wr_drop) else $error("write request kept after ack");
   property p_idle; !busy && !$past(busy) |-> !mem_rd_req && !mem_wr_req; endproperty
   a_idle: assert property (p_idle) else $error("memory traffic while idle");
   property p_rd_busy; $rose(mem_rd_req) |-> busy; endproperty
   a_rd_busy: assert property (p_rd_busy) else $error("fetch outside an operation");
   property p_wr_busy; $rose(mem_wr_req) |-> busy; endproperty
   a_wr_busy: assert property (p_wr_busy) else $error("store outside an operation");
   property p_freeze; wr_acc && busy && paddr != irz_pkg::OFF_STATUS |-> pslverr; endproperty
   a_freeze: assert property (p_freeze) else $error("setting accepted while busy");
   property p_start; wr_acc && paddr == irz_pkg::OFF_CTRL && pwdata[irz_pkg::CTRL_START] && !busy && !pslverr |=> busy; endproperty
   a_start: assert property (p_start) else $error("start did not raise busy");
endmodule : irz_resizer_properties
bind irz_resizer irz_resizer_properties u_props (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
   .pslverr, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_wr_req, .mem_wr_addr, .mem_wr_data, .mem_wr_ack, .busy);
`default_nettype wire

// File: irz_mem_model.sv
// Byte memory partner: read answers alternate prompt and slow, writes take the pace left by the last read
`timescale 1ns/1ps
`default_nettype none
module irz_mem_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_rd_req,
   input wire logic [31:0] mem_rd_addr,
   output logic mem_rd_ack,
   output logic [7:0] mem_rd_data,
   input wire logic mem_wr_req,
   input wire logic [31:0] mem_wr_addr,
   input wire logic [7:0] mem_wr_data,
   output logic mem_wr_ack
);
   logic [7:0] m [int];
   logic [1:0] rc, wc;
   logic slow;
   // Unwritten places outside the source page read unknown, so stray reads show up
   function automatic logic [7:0] rd(input logic [31:0] a);
      return m.exists(int'(a)) ? m[int'(a)] : (a[31:12] == 20'h00001 ? a[7:0] + a[15:8] : 8'hXX);
   endfunction : rd
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_rd_ack <= 1'b0;
         mem_wr_ack <= 1'b0;
         mem_rd_data <= 8'h00;
         rc <= 2'h0;
         wc <= 2'h0;
         slow <= 1'b0;
      end else begin
         mem_rd_ack <= 1'b0;
         mem_wr_ack <= 1'b0;
         mem_rd_data <= ~mem_rd_data;
         if (mem_rd_req && !mem_rd_ack) begin
            rc <= rc + 2'h1;
            if (rc == {slow, slow}) begin
               mem_rd_ack <= 1'b1;
               mem_rd_data <= rd(mem_rd_addr);
               rc <= 2'h0;
               slow <= ~slow;
            end
         end
         if (mem_wr_req && !mem_wr_ack) begin
            wc <= wc + 2'h1;
            if (wc == {slow, slow}) begin
               mem_wr_ack <= 1'b1;
               m[int'(mem_wr_addr)] = mem_wr_data;
               wc <= 2'h0;
            end
         end
      end
   end
endmodule : irz_mem_model
`default_nettype wire

// File: tb.sv
// Self-checking bench for the image resizer
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, mem_rd_addr, mem_wr_addr;
   logic pready, pslverr, mem_rd_req, mem_rd_ack, mem_wr_req, mem_wr_ack, busy;
   logic cap_en = 0, cap_hsync = 0, cap_vsync = 0, cap_valid = 0, prv_en = 0, prv_hsync = 0, prv_vsync = 0, prv_valid = 0;
   logic [15:0] cap_data = '0, prv_data = '0;
   logic [7:0] mem_rd_data, mem_wr_data;
   int fails = 0, n_tests = 0, cyc = 0;
   always #10 pclk = ~pclk;
   irz_resizer dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .cap_en, .cap_hsync, .cap_vsync, .cap_valid, .cap_data, .prv_en, .prv_hsync, .prv_vsync, .prv_valid,
      .prv_data, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .mem_wr_req, .mem_wr_addr,
      .mem_wr_data, .mem_wr_ack, .busy);
   irz_mem_model mem (.pclk, .presetn, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .mem_wr_req,
      .mem_wr_addr, .mem_wr_data, .mem_wr_ack);
   task summarize;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         summarize();
      end
   end
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // Access lasts until pready is seen high; only the bench timeout ends a stuck wait
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1, a, d, r, e);
   endtask : wr
   task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(0, a, 0, r, e);
      chk(nm, r, exp);
   endtask : rd_chk
   task wait_idle;
      while (busy !== 1'b0) @(posedge pclk);
   endtask : wait_idle
   task cfg(input logic [31:0] ratio, start, isz, iad, istep);
      mem.m.delete();
      wr(irz_pkg::OFF_RATIO, ratio);
      wr(irz_pkg::OFF_START, start);
      wr(irz_pkg::OFF_IN_SIZE, isz);
      wr(irz_pkg::OFF_OUT_SIZE, 32'h00020010);
      wr(irz_pkg::OFF_IN_ADDR, iad);
      wr(irz_pkg::OFF_IN_STEP, istep);
      wr(irz_pkg::OFF_OUT_ADDR, 32'h00003000);
      wr(irz_pkg::OFF_OUT_STEP, 32'h00000020);
      wr(irz_pkg::OFF_SCR_ADDR, 32'h00002000);
   endtask : cfg
   task t_regs;
      logic [31:0] r;
      logic e;
      rd_chk("ratio_reset", irz_pkg::OFF_RATIO, 32'h01000100);
      wr(irz_pkg::OFF_OUT_ADDR, 32'h1234567F);
      rd_chk("out_addr_low_bits", irz_pkg::OFF_OUT_ADDR, 32'h12345660);
      apb(0, 12'h030, 0, r, e);
      chk("unmapped_err", 32'(e), 32'h1);
   endtask : t_regs
   task t_mem(input int hr, input logic edge_on);
      logic [31:0] r, a;
      logic e;
      int tp, fv, fp, ev;
      tp = (hr > 512) ? 8 : 4;
      // Only tap 0 is unity, so each output copies one source pixel
      for (int k = 0; k < 32; k++) begin
         wr(irz_pkg::OFF_HCOEF + 12'(4 * k), (k % tp == 0) ? 32'h100 : 32'h0);
         wr(12'h100 + 12'(4 * k), (k % 4 == 0) ? 32'h100 : 32'h0);
      end
      cfg(32'h01000000 | hr, 32'h3, 32'h00080000 | (16 * hr / 256 + 16), 32'h1005, 32'h60);
      wr(irz_pkg::OFF_CTRL, edge_on ? 32'h17 : 32'h7);
      apb(1, irz_pkg::OFF_RATIO, 32'h01000100, r, e);
      chk("busy_write_err", 32'(e), 32'h1);
      apb(0, irz_pkg::OFF_STATUS, 0, r, e);
      chk("status_busy", 32'(r[irz_pkg::ST_BUSY]), 32'h1);
      wait_idle();
      rd_chk("ratio_kept", irz_pkg::OFF_RATIO, 32'h01000000 | hr);
      for (int y = 0; y < 2; y++)
         for (int x = 0; x < 16; x++) begin
            a = 32'h1000 + y * 32'h60 + 3 + x * hr / 256;
            fv = 8'(a[7:0] + a[15:8]);
            // Edge step leans on the unenhanced previous pixel of the same row
            ev = (edge_on && x > 0) ? fv + ((fv - fp) >>> 1) : fv;
            ev = (ev < 0) ? 0 : ((ev > 255) ? 255 : ev);
            fp = fv;
            chk("mem_out", 32'(mem.rd(32'h3000 + y * 32 + x)), 32'(ev));
         end
   endtask : t_mem
   task t_live;
      logic [7:0] l;
      cfg(32'h01000100, 32'h00010002, 32'h00060020, 32'h0, 32'h0);
      wr(irz_pkg::OFF_CTRL, 32'h9);
      cap_en <= 1;
      prv_en <= 1;
      @(posedge pclk);
      cap_vsync <= 1;
      prv_vsync <= 1;
      @(posedge pclk);
      cap_vsync <= 0;
      prv_vsync <= 0;
      for (int r = 0; r < 9; r++) begin
         @(posedge pclk);
         cap_hsync <= 1;
         prv_hsync <= 1;
         @(posedge pclk);
         cap_hsync <= 0;
         prv_hsync <= 0;
         for (int c = 0; c < 36; c++) begin
            l = 8'(r * 16 + c);
            @(posedge pclk);
            cap_valid <= 1;
            prv_valid <= 1;
            cap_data <= {l, 8'h80};
            prv_data <= {~l, 8'h7F};
            @(posedge pclk);
            cap_valid <= 0;
            prv_valid <= 0;
            cap_data <= ~cap_data;
            prv_data <= ~prv_data;
            repeat (14) @(posedge pclk);
         end
      end
      wait_idle();
      cap_en <= 0;
      prv_en <= 0;
      // Pixels spaced wider than a write: no overrun, engine back to idle
      rd_chk("status_clean", irz_pkg::OFF_STATUS, 32'h0);
      for (int y = 0; y < 2; y++)
         for (int x = 0; x < 16; x++)
            chk("live_out", 32'(mem.rd(32'h3000 + y * 32 + x)), 32'((1 + y) * 16 + 2 + x));
   endtask : t_live
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      t_regs();
      t_mem(512, 1'b0);
      t_mem(1024, 1'b0);
      t_mem(1024, 1'b1);
      t_mem(256, 1'b0);
      t_live();
      summarize();
   end
endmodule : tb
`default_nettype wire
